// file: include/clcd_pkg.sv
// Constants shared by the character display host port.
package clcd_pkg;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic       BUS_WIDTH_RESET = 1'b1;
	localparam logic       TWO_LINE_RESET  = 1'b1;
	localparam logic [6:0] ADDR_RESET      = 7'h00;
	localparam logic [7:0] BYTE_RESET      = 8'h00;

	// ----------------------------------------
	// Command byte field positions
	// ----------------------------------------
	localparam int CMD_SET_DISPLAY_ADDR_BIT = 7;
	localparam int CMD_SET_PATTERN_ADDR_BIT = 6;
	localparam int CMD_FUNCTION_SET_BIT     = 5;
	localparam int CMD_BUS_WIDTH_BIT        = 4;
	localparam int CMD_LINE_COUNT_BIT       = 3;

	// ----------------------------------------
	// Status word layout
	// ----------------------------------------
	localparam int STATUS_BUSY_BIT = 7;

	// ----------------------------------------
	// Memory sizes and display address map
	// ----------------------------------------
	localparam int         DISPLAY_DEPTH   = 80;
	localparam int         PATTERN_DEPTH   = 64;
	localparam logic [6:0] LINE1_FIRST     = 7'h00;
	localparam logic [6:0] LINE1_LAST      = 7'h27;
	localparam logic [6:0] LINE2_FIRST     = 7'h40;
	localparam logic [6:0] LINE2_LAST      = 7'h67;
	localparam logic [6:0] LINE2_BASE      = 7'h28;
	localparam logic [6:0] ONE_LINE_LAST   = 7'h4F;

endpackage

// file: rtl/clcd_host_port.sv
// Host-facing parallel port of a character display controller with its RAMs.

// Overview of operation
// - Host bus runs four or eight bits wide.
// - Command holding and RAM transfer registers exist.
// - Data read refills buffer from next address.
// - Data write lands in addressed RAM location.
// - Command register is never read back.
// - Select and direction lines choose the operation.
// - Status read: busy bit seven, address below.
// - Busy blocks acceptance of further commands.
// - Address pointer steps one after each data read or write.
// - Address commands load the address pointer.
// - Last address command picks display/pattern RAM.
// - Eighty display bytes, seven-bit address pointer.
// - Two-line map is 00-27 and 40-67.
// - One-line map covers a single linear range.
module clcd_host_port
	import clcd_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Host pins
	input  wire logic       register_select_line,
	input  wire logic       read_write_line,
	input  wire logic       enable_strobe,
	input  wire logic [7:0] bus_in,
	output logic      [7:0] bus_out,
	output logic            bus_oe,
	// Command stream to the instruction executor
	output logic            cmd_valid,
	output logic      [7:0] cmd_data,
	input  wire logic       cmd_ready,
	input  wire logic       exec_busy,
	// Step direction from the entry mode logic
	input  wire logic       addr_increment
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Synchronisers, mode bits, pointer, buffers, queue and read drive all live in one record.
	typedef struct packed {
		logic       rs_s1;
		logic       rs_s2;
		logic       rw_s1;
		logic       rw_s2;
		logic       en_s1;
		logic       en_s2;
		logic       en_s3;
		logic [7:0] din_s1;
		logic [7:0] din_s2;
		logic [7:0] din_hold;
		logic       bus_width_select;
		logic       two_line;
		logic       pattern_sel;
		logic [6:0] ram_address_pointer;
		logic [7:0] ram_transfer_buffer;
		logic [7:0] command_holding_reg;
		logic       refill;
		logic       nib_phase;
		logic [3:0] nib_high;
		logic [7:0] bus_out;
		logic       bus_oe;
		logic       out_valid;
		logic [7:0] out_data;
		logic       skid_valid;
		logic [7:0] skid_data;
	} clcd_state_t;

	clcd_state_t s;
	clcd_state_t next_s;

	// Neither store is reset, so only rows that were written hold meaningful bytes.
	logic [7:0] display_char_ram [DISPLAY_DEPTH];
	logic [7:0] user_pattern_ram [PATTERN_DEPTH];

	logic       ram_we;
	logic       ram_pattern;
	logic [6:0] ram_index;
	logic [7:0] ram_wdata;
	logic [6:0] rd_index;
	logic [7:0] rd_byte;
	logic       internal_op_flag;
	logic       fall;
	logic       done;
	logic [7:0] full_byte;
	logic [7:0] rd_word;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Translate the pointer into a physical display RAM row.
	function automatic logic [6:0] display_index(input logic [6:0] a, input logic two);
		logic [6:0] r;
		r = a;
		if (two && a[6]) begin
			r = {1'b0, a[5:0]} + LINE2_BASE;
		end
		return r;
	endfunction

	// Step the pointer by one, wrapping inside the active map.
	// In two-line mode a step off either end of a line lands on the other line; in one-line mode 4F and 00 wrap to each other.
	function automatic logic [6:0] step(input logic [6:0] a, input logic inc, input logic pat, input logic two);
		logic [6:0] r;
		r = inc ? a + 7'h01 : a - 7'h01;
		if (pat) begin
			r = {1'b0, r[5:0]};
		end else if (two) begin
			if (inc && a == LINE1_LAST) begin
				r = LINE2_FIRST;
			end else if (inc && a == LINE2_LAST) begin
				r = LINE1_FIRST;
			end else if (!inc && a == LINE2_FIRST) begin
				r = LINE1_LAST;
			end else if (!inc && a == LINE1_FIRST) begin
				r = LINE2_LAST;
			end
		end else begin
			if (inc && a == ONE_LINE_LAST) begin
				r = LINE1_FIRST;
			end else if (!inc && a == LINE1_FIRST) begin
				r = ONE_LINE_LAST;
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// RAM read port
	// ----------------------------------------
	// The read is asynchronous, so a refill lands one cycle after the pointer moves.
	assign rd_index = s.pattern_sel ? {1'b0, s.ram_address_pointer[5:0]}
		: display_index(s.ram_address_pointer, s.two_line);
	assign rd_byte = s.pattern_sel ? user_pattern_ram[rd_index[5:0]]
		: (rd_index < 7'(DISPLAY_DEPTH) ? display_char_ram[rd_index] : BYTE_RESET);

	// Busy covers both a running command and a full command queue.
	// A full queue reads as busy, so a polling host can never overrun it.
	assign internal_op_flag = exec_busy | (s.out_valid & s.skid_valid);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		ram_we = 1'b0;
		ram_pattern = s.pattern_sel;
		ram_index = rd_index;
		ram_wdata = BYTE_RESET;

		// ----------------------------------------
		// Pin synchronisers
		// ----------------------------------------
		// Two flops guard every pin, and the strobe has a third so that its fall can be seen.
		next_s.rs_s1 = register_select_line;
		next_s.rs_s2 = s.rs_s1;
		next_s.rw_s1 = read_write_line;
		next_s.rw_s2 = s.rw_s1;
		next_s.en_s1 = enable_strobe;
		next_s.en_s2 = s.en_s1;
		next_s.en_s3 = s.en_s2;
		next_s.din_s1 = bus_in;
		next_s.din_s2 = s.din_s1;
		// Data is captured while the strobe is high, since the host may drop it just after the fall.
		if (s.en_s2) begin
			next_s.din_hold = s.din_s2;
		end

		// ----------------------------------------
		// Nibble assembly
		// ----------------------------------------
		// In narrow mode the first strobe of a pair only stores the high nibble.
		fall = s.en_s3 & ~s.en_s2;
		done = fall & (s.bus_width_select | s.nib_phase);
		full_byte = s.bus_width_select ? s.din_hold : {s.nib_high, s.din_hold[7:4]};
		if (fall && !s.bus_width_select) begin
			next_s.nib_phase = ~s.nib_phase;
			next_s.nib_high = s.din_hold[7:4];
		end

		// ----------------------------------------
		// Command queue
		// ----------------------------------------
		// Two entries let one command wait while the executor still holds the head.
		if (s.out_valid && cmd_ready) begin
			next_s.out_valid = s.skid_valid;
			next_s.out_data = s.skid_data;
			next_s.skid_valid = 1'b0;
		end

		// ----------------------------------------
		// Transfer buffer refill
		// ----------------------------------------
		// Refill the transfer buffer from the current address.
		next_s.refill = 1'b0;
		if (s.refill) begin
			next_s.ram_transfer_buffer = rd_byte;
		end

		// ----------------------------------------
		// Host access decode
		// ----------------------------------------
		// Data accesses are taken even while busy; only commands can be refused.
		if (done) begin
			case ({s.rs_s2, s.rw_s2})
				2'b00: begin
					// A refused command leaves no trace, so the host has to poll the busy bit first.
					if (!internal_op_flag) begin
						next_s.command_holding_reg = full_byte;
						if (!next_s.out_valid) begin
							next_s.out_valid = 1'b1;
							next_s.out_data = full_byte;
						end else begin
							next_s.skid_valid = 1'b1;
							next_s.skid_data = full_byte;
						end
						if (full_byte[CMD_SET_DISPLAY_ADDR_BIT]) begin
							next_s.pattern_sel = 1'b0;
							next_s.ram_address_pointer = full_byte[6:0];
							next_s.refill = 1'b1;
						end else if (full_byte[CMD_SET_PATTERN_ADDR_BIT]) begin
							next_s.pattern_sel = 1'b1;
							next_s.ram_address_pointer = {1'b0, full_byte[5:0]};
							next_s.refill = 1'b1;
						end else if (full_byte[CMD_FUNCTION_SET_BIT]) begin
							next_s.bus_width_select = full_byte[CMD_BUS_WIDTH_BIT];
							next_s.two_line = full_byte[CMD_LINE_COUNT_BIT];
							next_s.nib_phase = 1'b0;
						end
					end
				end
				2'b10: begin
					// The written byte stays in the buffer only until the refill replaces it.
					next_s.ram_transfer_buffer = full_byte;
					ram_we = 1'b1;
					ram_wdata = full_byte;
					next_s.ram_address_pointer = step(s.ram_address_pointer, addr_increment,
						s.pattern_sel, s.two_line);
					next_s.refill = 1'b1;
				end
				2'b11: begin
					next_s.ram_address_pointer = step(s.ram_address_pointer, addr_increment,
						s.pattern_sel, s.two_line);
					// The byte has already left on the bus; the step readies the next one.
					next_s.refill = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// ----------------------------------------
		// Host read drive
		// ----------------------------------------
		// Host read drive: status or transfer buffer, never the command register.
		rd_word = s.rs_s2 ? s.ram_transfer_buffer : {internal_op_flag, s.ram_address_pointer};
		next_s.bus_oe = s.en_s2 & s.rw_s2;
		if (s.bus_width_select) begin
			next_s.bus_out = rd_word;
		end else begin
			next_s.bus_out = {(s.nib_phase ? rd_word[3:0] : rd_word[7:4]), 4'h0};
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			// Only the two mode bits start away from zero; the pointer loads ADDR_RESET, which is zero.
			s <= '0;
			s.bus_width_select <= BUS_WIDTH_RESET;
			s.two_line <= TWO_LINE_RESET;
			s.ram_address_pointer <= ADDR_RESET;
		end else begin
			s <= next_s;
		end
	end

	// RAM contents are not reset, as in any real character store.
	always_ff @(posedge sys_clk) begin
		if (ram_we) begin
			if (ram_pattern) begin
				user_pattern_ram[ram_index[5:0]] <= ram_wdata;
			end else if (ram_index < 7'(DISPLAY_DEPTH)) begin
				display_char_ram[ram_index] <= ram_wdata;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus_out   = s.bus_out;
	assign bus_oe    = s.bus_oe;
	assign cmd_valid = s.out_valid;
	assign cmd_data  = s.out_data;

endmodule

// file: dv/clcd_host_port_assertions.sv
// Checker for the host port pins and the command stream.
module clcd_port_chk
	import clcd_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// Host pins
	input wire logic       register_select_line,
	input wire logic       read_write_line,
	input wire logic       enable_strobe,
	input wire logic [7:0] bus_in,
	input wire logic [7:0] bus_out,
	input wire logic       bus_oe,
	// Command stream
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic       cmd_ready,
	input wire logic       exec_busy,
	input wire logic       addr_increment
);
	timeunit 1ns;
	timeprecision 1ps;
	logic narrow;
	logic half;
	// Bus width follows the function-set commands on the stream; half counts strobes of a nibble pair.
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			narrow <= !BUS_WIDTH_RESET;
			half <= 1'b0;
		end else if (cmd_valid && cmd_ready && !cmd_data[CMD_SET_DISPLAY_ADDR_BIT]
			&& !cmd_data[CMD_SET_PATTERN_ADDR_BIT] && cmd_data[CMD_FUNCTION_SET_BIT]) begin
			narrow <= !cmd_data[CMD_BUS_WIDTH_BIT];
			half <= 1'b0;
		end else if (narrow && $fell(enable_strobe)) begin
			half <= !half;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_oe_on_read: assert property (bus_oe |-> $past(read_write_line, 3))
		else $error("bus driven outside a read");
	a_oe_rise: assert property ($rose(enable_strobe) && read_write_line |-> ##3 bus_oe)
		else $error("bus not driven after read strobe");
	a_oe_fall: assert property ($fell(enable_strobe) |-> ##3 !bus_oe)
		else $error("bus still driven after strobe");
	a_status_busy: assert property (bus_oe && !$past(register_select_line, 3) && $past(exec_busy)
		&& !(narrow && $past(half, 3)) |-> bus_out[7])
		else $error("busy bit low while busy");
	a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
		else $error("command dropped before taken");
	a_cmd_accept: assert property ($fell(enable_strobe) && !register_select_line && !read_write_line
		&& !exec_busy && !cmd_valid && (!narrow || half) |-> ##3 cmd_valid)
		else $error("command write not forwarded");
	a_busy_refuse: assert property ($fell(enable_strobe) && !register_select_line && !read_write_line
		&& exec_busy && !cmd_valid |-> ##1 !cmd_valid [*5])
		else $error("command taken while busy");
	a_data_no_cmd: assert property ($fell(enable_strobe) && register_select_line && !cmd_valid
		|-> ##1 !cmd_valid [*5])
		else $error("data access reached command stream");
endmodule

bind clcd_host_port clcd_port_chk u_chk (.*);

// file: dv/clcd_host_model.sv
// Host processor model that drives the strobe bus pins.
module clcd_host_model (
	// Clock
	input wire logic       sys_clk,
	// Pins toward the port
	output logic           register_select_line,
	output logic           read_write_line,
	output logic           enable_strobe,
	output logic     [7:0] bus_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {register_select_line, read_write_line, enable_strobe, bus_in} = 11'h000;

	// Select and direction settle a cycle before the strobe and stay until the next access.
	task automatic access(input logic sel, input logic rd, input logic [7:0] d);
		@(negedge sys_clk);
		register_select_line = sel;
		read_write_line = rd;
		bus_in = rd ? ~bus_in : d;
		@(negedge sys_clk);
		enable_strobe = 1'b1;
		repeat (25) @(negedge sys_clk);
		enable_strobe = 1'b0;
		repeat (4) @(negedge sys_clk);
		// Released data lines must not keep showing the old byte.
		bus_in = ~bus_in;
		repeat (20) @(negedge sys_clk);
	endtask
endmodule

// file: dv/clcd_host_port_bench.sv
// Self-checking bench for the character display host port.
module clcd_host_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic            sys_clk = 1'b0;
	logic            rst_n = 1'b0;
	logic            cmd_ready = 1'b0;
	logic            exec_busy = 1'b0;
	logic            addr_increment = 1'b1;
	logic            prev_oe = 1'b0;
	wire logic       register_select_line;
	wire logic       read_write_line;
	wire logic       enable_strobe;
	wire logic [7:0] bus_in;
	logic      [7:0] bus_out;
	logic            bus_oe;
	logic            cmd_valid;
	logic      [7:0] cmd_data;
	logic      [7:0] last_out;
	logic      [7:0] d [5];
	logic      [7:0] exp_q [$];
	int              mismatches = 0;
	int              n_compared = 0;
	int              seed = 33;
	int              cycles = 0;

	clcd_host_port dut (.*);
	clcd_host_model host (.*);

	always #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) cmd_ready = !exec_busy && $random(seed) & 1;

	task automatic stop_test();
		if (exp_q.size() != 0) begin
			mismatches++;
			$display("CHECK FAILED pending notes expected 0 seen %0d", exp_q.size());
		end
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen);
		logic [7:0] e;
		n_compared++;
		if (exp_q.size() == 0) begin
			mismatches++;
			$display("CHECK FAILED %s expected none seen %h", what, seen);
			return;
		end
		e = exp_q.pop_front();
		if (seen !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, seen);
		end
	endtask

	// A refused command leaves no note, so a stray one shows up as a mismatch.
	task automatic cmd(input logic [7:0] v);
		if (!exec_busy)
			exp_q.push_back(v);
		host.access(1'b0, 1'b0, v);
	endtask

	task automatic rd(input logic sel, input logic [7:0] v);
		exp_q.push_back(v);
		host.access(sel, 1'b1, 8'h00);
	endtask

	// Narrow bus: each byte travels as two strobes, high nibble first on bits 7:4.
	task automatic cmd4(input logic [7:0] v);
		exp_q.push_back(v);
		host.access(1'b0, 1'b0, {v[7:4], 4'h0});
		host.access(1'b0, 1'b0, {v[3:0], 4'h0});
	endtask

	task automatic wr4(input logic [7:0] v);
		host.access(1'b1, 1'b0, {v[7:4], 4'h0});
		host.access(1'b1, 1'b0, {v[3:0], 4'h0});
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 5000) begin
			mismatches++;
			stop_test();
		end
		if (cmd_valid && cmd_ready)
			check("command", cmd_data);
		if (bus_oe)
			last_out = bus_out;
		if (prev_oe && !bus_oe)
			check("read", last_out);
		prev_oe = bus_oe;
	end

	initial begin
		foreach (d[i]) d[i] = 8'($random(seed));
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		cmd(8'hA6);
		host.access(1'b1, 1'b0, d[0]);
		host.access(1'b1, 1'b0, d[1]);
		host.access(1'b1, 1'b0, d[2]);
		rd(1'b0, 8'h41);
		cmd(8'hA6);
		rd(1'b1, d[0]);
		rd(1'b1, d[1]);
		rd(1'b1, d[2]);
		$display("test display ram done");
		addr_increment = 1'b0;
		host.access(1'b1, 1'b0, d[3]);
		rd(1'b0, 8'h40);
		cmd(8'h45);
		host.access(1'b1, 1'b0, d[4]);
		cmd(8'hC1);
		rd(1'b1, d[3]);
		cmd(8'h45);
		rd(1'b1, d[4]);
		$display("test pattern ram done");
		exec_busy = 1'b1;
		cmd(8'h80);
		rd(1'b0, 8'h84);
		exec_busy = 1'b0;
		rd(1'b0, 8'h04);
		$display("test busy done");
		cmd(8'h20);
		addr_increment = 1'b1;
		cmd4(8'hCF);
		wr4(d[0]);
		wr4(d[1]);
		rd(1'b0, 8'h00);
		rd(1'b0, 8'h10);
		cmd4(8'hCF);
		rd(1'b1, {d[0][7:4], 4'h0});
		rd(1'b1, {d[0][3:0], 4'h0});
		rd(1'b1, {d[1][7:4], 4'h0});
		rd(1'b1, {d[1][3:0], 4'h0});
		$display("test narrow bus done");
		stop_test();
	end
endmodule
